// file: rtl/acc_address_current_cal.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"

module acc_address_current_cal #(
    parameter int READ_W = 12,
    parameter int OFS_STEP = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Management bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Address strap and stored settings
    input wire logic [6:0] addr_strap_i,
    input wire logic address_override_bit_i,
    input wire logic [6:0] nvm_bus_address_i,
    input wire logic [3:0] nvm_vid_link_address_i,
    input wire logic [7:0] nvm_output_current_trim_i,
    input wire logic [7:0] nvm_input_current_trim_i,
    // Telemetry
    input wire logic [READ_W-1:0] output_current_raw_i,
    input wire logic [READ_W-1:0] input_current_raw_i,
    output logic [READ_W-1:0] output_current_reading_o,
    output logic [READ_W-1:0] input_current_reading_o,
    // Register contents
    output logic [6:0] responding_address_o,
    output logic [6:0] bus_address_o,
    output logic [3:0] vid_link_address_field_o,
    output logic vid_link_address_valid_o,
    output logic [7:0] output_current_trim_o,
    output logic [7:0] input_current_trim_o
);

    acc_pkg::acc_regs_s q;
    acc_pkg::acc_regs_s n;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic last_bit;
    logic mapped;
    logic [7:0] rdata;

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        case (q.ptr)
            `ACC_OFS_BUS_ADDR: rdata = {1'b0, q.bus_addr};
            `ACC_OFS_VID_ADDR: rdata = {`ACC_RST_NIBBLE, q.vid_addr};
            `ACC_OFS_OUT_TRIM: rdata = q.out_trim;
            `ACC_OFS_IN_TRIM: rdata = q.in_trim;
            default: begin
                rdata = `ACC_RST_BYTE;
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus slave and register file
    // ------------------------------------------------------------------------
    always_comb begin
        n = q;
        n.scl = scl_i;
        n.sda = sda_i;
        start = q.scl && scl_i && q.sda && !sda_i;
        stop = q.scl && scl_i && !q.sda && sda_i;
        rise = scl_i && !q.scl;
        fall = !scl_i && q.scl;
        last_bit = q.cnt == `ACC_BITS_PER_BYTE;
        if (!q.loaded) begin
            // Stored settings arrive as levels; they are caught once after reset.
            n.loaded = 1'b1;
            n.resp_addr = address_override_bit_i ? nvm_bus_address_i : addr_strap_i;
            n.bus_addr = address_override_bit_i ? nvm_bus_address_i : addr_strap_i;
            n.vid_addr = nvm_vid_link_address_i;
            n.vid_valid = nvm_vid_link_address_i <= `ACC_VID_ADDR_MAX;
            n.out_trim = nvm_output_current_trim_i;
            n.in_trim = nvm_input_current_trim_i;
        end else if (stop) begin
            n.st = acc_pkg::ACC_IDLE;
            n.sda_oe = 1'b0;
        end else if (start) begin
            n.st = acc_pkg::ACC_RX_ADDR;
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else begin
            case (q.st)
                acc_pkg::ACC_RX_ADDR, acc_pkg::ACC_RX_CMD, acc_pkg::ACC_RX_DATA: begin
                    if (rise) begin
                        n.sh = {q.sh[6:0], sda_i};
                        n.cnt = 4'(q.cnt + 4'h1);
                    end else if (fall && last_bit) begin
                        n.st = acc_pkg::ACC_IDLE;
                        if (q.st == acc_pkg::ACC_RX_ADDR) begin
                            // Only the address latched at start-up is answered.
                            if (q.sh[7:1] == q.resp_addr) begin
                                n.sda_oe = 1'b1;
                                n.st = acc_pkg::ACC_ACK;
                                n.after = q.sh[`ACC_RW_BIT] ? acc_pkg::ACC_TX_DATA
                                                            : acc_pkg::ACC_RX_CMD;
                            end
                        end else if (q.st == acc_pkg::ACC_RX_CMD) begin
                            n.ptr = q.sh;
                            if (q.sh >= `ACC_OFS_BUS_ADDR && q.sh <= `ACC_OFS_IN_TRIM) begin
                                n.sda_oe = 1'b1;
                                n.st = acc_pkg::ACC_ACK;
                                n.after = acc_pkg::ACC_RX_DATA;
                            end
                        end else begin
                            n.sda_oe = mapped;
                            n.st = mapped ? acc_pkg::ACC_ACK : acc_pkg::ACC_IGNORE;
                            n.after = acc_pkg::ACC_IGNORE;
                            case (q.ptr)
                                `ACC_OFS_BUS_ADDR: n.bus_addr = q.sh[`ACC_BUS_ADDR_MSB:0];
                                `ACC_OFS_VID_ADDR: begin
                                    n.vid_addr = q.sh[`ACC_VID_ADDR_MSB:0];
                                    n.vid_valid = q.sh[`ACC_VID_ADDR_MSB:0]
                                        <= `ACC_VID_ADDR_MAX;
                                end
                                `ACC_OFS_OUT_TRIM: n.out_trim = q.sh;
                                `ACC_OFS_IN_TRIM: n.in_trim = q.sh;
                                default: n.sda_oe = 1'b0;
                            endcase
                        end
                    end
                end
                acc_pkg::ACC_ACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        n.st = q.after;
                        n.sda_oe = 1'b0;
                        if (q.after == acc_pkg::ACC_TX_DATA) begin
                            n.sh = rdata;
                            n.sda_oe = !rdata[7];
                        end
                    end
                end
                acc_pkg::ACC_TX_DATA: begin
                    if (rise) begin
                        n.cnt = 4'(q.cnt + 4'h1);
                    end else if (fall && last_bit) begin
                        n.sda_oe = 1'b0;
                        n.st = acc_pkg::ACC_TX_ACK;
                    end else if (fall) begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.sda_oe = !q.sh[6];
                    end
                end
                acc_pkg::ACC_TX_ACK: begin
                    if (rise) begin
                        n.st = acc_pkg::ACC_IGNORE;
                    end
                end
                acc_pkg::ACC_IDLE, acc_pkg::ACC_IGNORE: begin
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.st = acc_pkg::ACC_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: acc_pkg::ACC_IDLE, after: acc_pkg::ACC_IDLE, scl: 1'b1, sda: 1'b1,
                   default: '0};
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------------
    // Telemetry trim
    // ------------------------------------------------------------------------
    acc_trim_calc #(
        .READ_W(READ_W),
        .OFS_STEP(OFS_STEP)
    ) u_out_trim (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(output_current_raw_i),
        .trim_i(q.out_trim),
        .reading_o(output_current_reading_o)
    );

    acc_trim_calc #(
        .READ_W(READ_W),
        .OFS_STEP(OFS_STEP)
    ) u_in_trim (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(input_current_raw_i),
        .trim_i(q.in_trim),
        .reading_o(input_current_reading_o)
    );

    // The pin is open drain; only the enable ever changes.
    assign sda_o = 1'b0;
    assign sda_oe_o = q.sda_oe;
    assign responding_address_o = q.resp_addr;
    assign bus_address_o = q.bus_addr;
    assign vid_link_address_field_o = q.vid_addr;
    assign vid_link_address_valid_o = q.vid_valid;
    assign output_current_trim_o = q.out_trim;
    assign input_current_trim_o = q.in_trim;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_RESP_ADDR_HELD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        q.loaded |=> $stable(q.resp_addr))
        else $error("Responding address changed after start-up.");

    AST_ADDR_SOURCE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(q.loaded) |-> q.resp_addr == ($past(address_override_bit_i)
            ? $past(nvm_bus_address_i) : $past(addr_strap_i)))
        else $error("Start-up address taken from the wrong source.");

    AST_RESV_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.st == acc_pkg::ACC_ACK && fall && q.after == acc_pkg::ACC_TX_DATA
            && q.ptr == `ACC_OFS_BUS_ADDR) |=> !q.sh[`ACC_RESV_BIT])
        else $error("Reserved address bit read as one.");

    AST_VID_UPPER_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.st == acc_pkg::ACC_ACK && fall && q.after == acc_pkg::ACC_TX_DATA
            && q.ptr == `ACC_OFS_VID_ADDR) |=> q.sh[7:4] == 4'h0)
        else $error("Unused link address bits read as nonzero.");

    AST_VID_VALID: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        q.loaded |-> q.vid_valid == (q.vid_addr <= `ACC_VID_ADDR_MAX))
        else $error("Link address validity disagrees with the code.");

    AST_VID_IMMEDIATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.loaded && q.st == acc_pkg::ACC_RX_DATA && fall && last_bit && !start && !stop
            && q.ptr == `ACC_OFS_VID_ADDR) |=> q.vid_addr == $past(q.sh[3:0]))
        else $error("Link address write did not act at once.");

    AST_TRIM_IMMEDIATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.loaded && q.st == acc_pkg::ACC_RX_DATA && fall && last_bit && !start && !stop
            && q.ptr == `ACC_OFS_OUT_TRIM) |=> q.out_trim == $past(q.sh))
        else $error("Output trim write did not act at once.");

    AST_SINGLE_BYTE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.st == acc_pkg::ACC_IGNORE && !start && !stop) |=> q.st == acc_pkg::ACC_IGNORE
            && !q.sda_oe)
        else $error("A second byte was taken in one transaction.");

endmodule : acc_address_current_cal
`default_nettype wire

// file: rtl/acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ACC_OFS_BUS_ADDR 8'hA2
`define ACC_OFS_VID_ADDR 8'hA3
`define ACC_OFS_OUT_TRIM 8'hA4
`define ACC_OFS_IN_TRIM 8'hA5

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define ACC_BUS_ADDR_MSB 6
`define ACC_RESV_BIT 7
`define ACC_VID_ADDR_MSB 3
`define ACC_GAIN_MSB 7
`define ACC_GAIN_LSB 4
`define ACC_OFS_MSB 3
`define ACC_RW_BIT 0
`define ACC_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_RST_ADDR 7'h00
`define ACC_RST_NIBBLE 4'h0
`define ACC_VID_ADDR_MAX 4'hD
`define ACC_GAIN_ZERO_CODE 5'h07
`define ACC_OFS_ZERO_CODE 5'h08
`define ACC_GAIN_RECIP 9'h052
`define ACC_GAIN_SHIFT 14

`endif

// file: rtl/acc_pkg.sv
package acc_pkg;

    typedef enum logic [2:0] {
        ACC_IDLE,
        ACC_RX_ADDR,
        ACC_RX_CMD,
        ACC_RX_DATA,
        ACC_ACK,
        ACC_TX_DATA,
        ACC_TX_ACK,
        ACC_IGNORE
    } acc_i2c_state_e;

    typedef struct packed {
        acc_i2c_state_e st;
        acc_i2c_state_e after;
        logic loaded;
        logic scl;
        logic sda;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic sda_oe;
        logic [6:0] resp_addr;
        logic [6:0] bus_addr;
        logic [3:0] vid_addr;
        logic vid_valid;
        logic [7:0] out_trim;
        logic [7:0] in_trim;
    } acc_regs_s;

endpackage : acc_pkg

// file: rtl/acc_trim_calc.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"

module acc_trim_calc #(
    parameter int READ_W = 12,
    parameter int OFS_STEP = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Raw reading and trim byte
    input wire logic [READ_W-1:0] raw_i,
    input wire logic [7:0] trim_i,
    // Trimmed reading
    output logic [READ_W-1:0] reading_o
);

    typedef struct packed {
        logic [READ_W-1:0] reading;
    } acc_trim_s;

    acc_trim_s q;
    acc_trim_s n;
    logic signed [READ_W:0] raw_s;
    logic signed [4:0] gain_s;
    logic signed [4:0] ofs_s;
    logic signed [READ_W+13:0] prod;
    logic signed [READ_W+13:0] gadj;

    // The gain is a fixed reciprocal multiply; a divider would cost far more area.
    always_comb begin
        n = q;
        raw_s = $signed({1'b0, raw_i});
        gain_s = $signed({1'b0, trim_i[`ACC_GAIN_MSB:`ACC_GAIN_LSB]})
            - $signed(`ACC_GAIN_ZERO_CODE);
        ofs_s = $signed({1'b0, trim_i[`ACC_OFS_MSB:0]}) - $signed(`ACC_OFS_ZERO_CODE);
        prod = raw_s * gain_s * $signed(`ACC_GAIN_RECIP);
        gadj = prod >>> `ACC_GAIN_SHIFT;
        // No clamp: a negative sum wraps down from the top of the range.
        n.reading = raw_i + gadj[READ_W-1:0] + READ_W'(ofs_s * OFS_STEP);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign reading_o = q.reading;

    AST_NEUTRAL_TRIM: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        trim_i == 8'h78 |=> reading_o == $past(raw_i))
        else $error("Neutral trim does not pass the raw reading.");

    AST_OFS_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (trim_i == 8'h70 && raw_i == '0) |=> reading_o == READ_W'(-8 * OFS_STEP))
        else $error("Negative offset did not wrap from the top.");

    AST_GAIN_UP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (trim_i == 8'hF8) |=> reading_o >= $past(raw_i) || reading_o < 12'h001)
        else $error("Top gain code lowered the reading.");

endmodule : acc_trim_calc
`default_nettype wire

// file: tb/acc_i2c_host.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Management bus host model
// ----------------------------------------------------------------------------
module acc_i2c_host (
    // Clock
    input wire logic sys_clk_i,
    // Bus pins
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Each change lands just after an edge and stands four clocks, so the
    // oversampling receiver never sees data move around an SCL edge.
    task automatic set_lines(input logic scl, input logic sda);
        @(posedge sys_clk_i);
        scl_o <= scl;
        sda_o <= sda;
        repeat (3) @(posedge sys_clk_i);
    endtask : set_lines

    task automatic clock_bit(input logic b, output logic s);
        set_lines(1'b0, b);
        set_lines(1'b1, b);
        s = sda_line_i;
        set_lines(1'b0, b);
    endtask : clock_bit

    task automatic start_cond;
        set_lines(1'b0, 1'b1);
        set_lines(1'b1, 1'b1);
        set_lines(1'b1, 1'b0);
        set_lines(1'b0, 1'b0);
    endtask : start_cond

    task automatic stop_cond;
        set_lines(1'b0, 1'b0);
        set_lines(1'b1, 1'b0);
        set_lines(1'b1, 1'b1);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        // The host refuses the byte; the device has already let go of the line after the eighth bit.
        clock_bit(1'b1, s);
    endtask : recv_byte

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                             input logic [7:0] data, output logic [2:0] acks);
        start_cond();
        send_byte({addr, 1'b0}, acks[2]);
        send_byte(cmd, acks[1]);
        send_byte(data, acks[0]);
        stop_cond();
    endtask : write_reg

    task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd,
                            output logic [7:0] data, output logic [2:0] acks);
        start_cond();
        send_byte({addr, 1'b0}, acks[2]);
        send_byte(cmd, acks[1]);
        start_cond();
        send_byte({addr, 1'b1}, acks[0]);
        recv_byte(data);
        stop_cond();
    endtask : read_reg
endmodule : acc_i2c_host

`default_nettype wire

// file: tb/address_and_current_cal_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"

module address_and_current_cal_regs_tb_top;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam int OFS_STEP = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic scl;
    wire logic host_sda;
    wire logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic [6:0] strap = 7'h00;
    logic ovr = 1'b0;
    logic [6:0] nvm_bus = 7'h00;
    logic [3:0] nvm_vid = 4'h0;
    logic [7:0] nvm_out = 8'h00;
    logic [7:0] nvm_in = 8'h00;
    logic [11:0] raw_out = 12'h000;
    logic [11:0] raw_in = 12'h000;
    logic [11:0] rd_out;
    logic [11:0] rd_in;
    logic [6:0] resp_addr;
    logic [6:0] bus_addr;
    logic [3:0] vid_field;
    logic vid_valid;
    logic [7:0] out_trim;
    logic [7:0] in_trim;
    logic [6:0] dev_addr;
    int seed = 77;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;
    // The device only pulls the data line low; the pull-up wins otherwise.
    assign sda_line = host_sda & ~(sda_oe & ~sda_o);

    acc_address_current_cal #(.READ_W(12), .OFS_STEP(OFS_STEP)) dut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_i(strap),
        .address_override_bit_i(ovr), .nvm_bus_address_i(nvm_bus),
        .nvm_vid_link_address_i(nvm_vid), .nvm_output_current_trim_i(nvm_out),
        .nvm_input_current_trim_i(nvm_in), .output_current_raw_i(raw_out),
        .input_current_raw_i(raw_in), .output_current_reading_o(rd_out),
        .input_current_reading_o(rd_in), .responding_address_o(resp_addr),
        .bus_address_o(bus_addr), .vid_link_address_field_o(vid_field),
        .vid_link_address_valid_o(vid_valid), .output_current_trim_o(out_trim),
        .input_current_trim_o(in_trim));

    acc_i2c_host host (.sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl),
        .sda_o(host_sda));

    // ------------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk

    // Gain steps are only roughly half a percent, so one count of rounding is allowed.
    task automatic chk_near(input string name, input logic [11:0] exp, input logic [11:0] got);
        logic [11:0] d;
        d = got - exp;
        check_count++;
        if ($isunknown(got) || !(d == 12'h000 || d == 12'h001 || d == 12'hFFF)) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk_near

    function automatic logic [11:0] exp_read(input logic [11:0] raw, input logic [7:0] trim);
        int p;
        int v;
        // Half a percent per gain step, rounded toward minus infinity like a shift.
        p = int'(raw) * (int'(trim[7:4]) - 7);
        v = p / 200;
        if (p < 0 && p % 200 != 0) begin
            v = v - 1;
        end
        v = int'(raw) + v + (int'(trim[3:0]) - 8) * OFS_STEP;
        return v[11:0];
    endfunction : exp_read

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        logic [2:0] acks;
        host.write_reg(dev_addr, cmd, data, acks);
        chk("write acks", 8'h07, {5'h00, acks});
    endtask : wr

    task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
        logic [2:0] acks;
        host.read_reg(dev_addr, cmd, data, acks);
        chk("read acks", 8'h07, {5'h00, acks});
    endtask : rd

    task automatic do_reset(input logic override);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        ovr <= override;
        strap <= 7'($random(seed));
        nvm_vid <= 4'($random(seed));
        nvm_out <= 8'($random(seed));
        nvm_in <= 8'($random(seed));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        dev_addr = override ? nvm_bus : strap;
        chk("responding address", {1'b0, dev_addr}, {1'b0, resp_addr});
        chk("bus address", {1'b0, dev_addr}, {1'b0, bus_addr});
        chk("stored link address", {4'h0, nvm_vid}, {4'h0, vid_field});
        chk("stored output trim", nvm_out, out_trim);
        chk("stored input trim", nvm_in, in_trim);
    endtask : do_reset

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] t_out;
        logic [7:0] t_in;
        logic [2:0] acks;
        logic [6:0] new_addr;
        do_reset(1'b0);
        rd(`ACC_OFS_BUS_ADDR, d);
        chk("strap address read", {1'b0, strap}, d);
        new_addr = strap ^ 7'h2A;
        wr(`ACC_OFS_BUS_ADDR, {1'b1, new_addr});
        rd(`ACC_OFS_BUS_ADDR, d);
        chk("written address read", {1'b0, new_addr}, d);
        chk("address kept", {1'b0, strap}, {1'b0, resp_addr});
        host.write_reg(new_addr, `ACC_OFS_VID_ADDR, 8'h01, acks);
        chk("new address ignored", 8'h00, {7'h00, acks[2]});
        host.write_reg(dev_addr, 8'hA6, 8'h55, acks);
        chk("unmapped command", 8'h04, {5'h00, acks});
        $display("test bus address finished");
        // Override set and stored, then the supply is cycled.
        nvm_bus <= new_addr;
        do_reset(1'b1);
        rd(`ACC_OFS_BUS_ADDR, d);
        chk("stored address read", {1'b0, new_addr}, d);
        $display("test override finished");
        for (int c = 0; c < 16; c++) begin
            wr(`ACC_OFS_VID_ADDR, {4'($random(seed)), 4'(c)});
            chk("link address field", 8'(c), {4'h0, vid_field});
            chk("link address valid", {7'h00, c <= 13}, {7'h00, vid_valid});
            rd(`ACC_OFS_VID_ADDR, d);
            chk("link address read", 8'(c), d);
        end
        $display("test link address finished");
        for (int i = 0; i < 6; i++) begin
            t_out = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h70 :
                (i == 3) ? 8'h78 : 8'($random(seed));
            t_in = (i == 0) ? 8'hF8 : 8'($random(seed));
            wr(`ACC_OFS_OUT_TRIM, t_out);
            wr(`ACC_OFS_IN_TRIM, t_in);
            chk("output trim", t_out, out_trim);
            chk("input trim", t_in, in_trim);
            rd(`ACC_OFS_OUT_TRIM, d);
            chk("output trim read", t_out, d);
            rd(`ACC_OFS_IN_TRIM, d);
            chk("input trim read", t_in, d);
            @(posedge sys_clk);
            // Loads stay above the largest negative offset, except one wrap case,
            // and low enough that the top gain code cannot overflow the range.
            raw_out <= (i == 2) ? 12'h000 : 12'h040 | (12'($random(seed)) & 12'hEFF);
            raw_in <= 12'h040 | (12'($random(seed)) & 12'hEFF);
            repeat (3) @(posedge sys_clk);
            chk_near("output reading", exp_read(raw_out, t_out), rd_out);
            chk_near("input reading", exp_read(raw_in, t_in), rd_in);
        end
        $display("test trims finished");
        end_sim();
    end
endmodule : address_and_current_cal_regs_tb_top

`default_nettype wire
